// ### rtl/mlsc_consts.svh
// constants for the max-limit and sleep command block
`ifndef MLSC_CONSTS_SVH
`define MLSC_CONSTS_SVH
// task-file register addresses (command block)
`define MLSC_TF_DATA      3'h0
`define MLSC_TF_FEATURE   3'h1
`define MLSC_TF_SECCNT    3'h2
`define MLSC_TF_SECNUM    3'h3
`define MLSC_TF_CYLLO     3'h4
`define MLSC_TF_CYLHI     3'h5
`define MLSC_TF_DEVHEAD   3'h6
`define MLSC_TF_COMMAND   3'h7
// control block address: device control on write, alternate status on read
`define MLSC_TF_DEVCTL    3'h6
// opcodes
`define MLSC_OP_SETMAXEXT 8'h37
`define MLSC_OP_RDNATEXT  8'h27
`define MLSC_OP_SLEEP_A   8'hE6
`define MLSC_OP_SLEEP_B   8'h99
// field positions
`define MLSC_DH_LBA       6
`define MLSC_SC_NVOPT     0
`define MLSC_DC_HOB       7
`define MLSC_DC_SRST      2
`define MLSC_ST_BSY       7
`define MLSC_ST_RDY       6
`define MLSC_ST_DSC       4
`define MLSC_ST_ERR       0
`define MLSC_ER_ABT       2
// limits and reset values
`define MLSC_LBA28_MAX    48'h0000_0FFF_FFFF
`define MLSC_STATUS_RST   8'h50
`define MLSC_ERROR_RST    8'h01
// host apb register map
`define MLSC_APB_ACCESS   12'h000
`define MLSC_APB_RESULT   12'h004
`define MLSC_APB_CTRL     12'h008
`define MLSC_ACC_READ     12
`define MLSC_ACC_CTL      11
`define MLSC_RES_BUSY     8
`define MLSC_RES_INTRQ    9
`endif

// ### rtl/mlsc_pkg.sv
// types shared by both ends of the max-limit and sleep command block
package mlsc_pkg;
  typedef enum logic [3:0] {
    MLSC_IDLE  = 4'b0001,
    MLSC_EXEC  = 4'b0010,
    MLSC_SPIN  = 4'b0100,
    MLSC_SLEEP = 4'b1000
  } mlsc_dev_state_e;

  typedef logic [47:0] mlsc_lba_t;
  typedef logic [7:0]  mlsc_byte_t;
endpackage

// ### rtl/mlsc_tf_if.sv
// task-file carrier between host controller and drive
`timescale 1ns/1ps
`default_nettype none
interface mlsc_tf_if;
  logic       tfWr;
  logic       tfRd;
  logic       tfCtl;
  logic [2:0] tfAddr;
  logic [7:0] tfWrData;
  logic       hardReset;
  logic [7:0] tfRdData;
  logic       tfRdValid;
  logic       intrq;

  modport device (input tfWr, tfRd, tfCtl, tfAddr, tfWrData, hardReset,
                  output tfRdData, tfRdValid, intrq);
  modport host   (output tfWr, tfRd, tfCtl, tfAddr, tfWrData, hardReset,
                  input tfRdData, tfRdValid, intrq);
endinterface
`default_nettype wire

// ### rtl/mlsc_device.sv
// drive end: set max address ext and sleep command handling
//
// Decided for this implementation: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_consts.svh"
module mlsc_device #(
  parameter bit SUPPORT_EXT = 1'b1
) (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  mlsc_tf_if.device             tf,
  input  wire mlsc_pkg::mlsc_lba_t nativeMaxLba,
  input  wire mlsc_pkg::mlsc_lba_t nvStoredLba,
  input  wire logic             nvStoredValid,
  input  wire logic             hpa28Established,
  input  wire logic             protLocked,
  input  wire logic             protFrozen,
  input  wire logic             addrOffsetMode,
  input  wire logic             mediaSpinning,
  input  wire mlsc_pkg::mlsc_lba_t accessLba,
  input  wire logic             accessReq,
  output logic                  accessAbort,
  output mlsc_pkg::mlsc_lba_t   maxLba,
  output logic [63:0]           idWords103to100,
  output logic [31:0]           idWords61to60,
  output logic                  nvWrite,
  output logic                  spinDownReq,
  output logic                  asleep
);
  import mlsc_pkg::*;

  typedef struct packed {
    mlsc_dev_state_e st;
    mlsc_byte_t feature;
    mlsc_byte_t scCur;
    mlsc_byte_t scPrev;
    logic [23:0] lbaCur;
    logic [23:0] lbaPrev;
    mlsc_byte_t devHead;
    mlsc_byte_t cmd;
    mlsc_byte_t error;
    mlsc_byte_t status;
    logic       hob;
    logic       lastNativeExt;
    logic       nvUsed;
    logic       powerUp;
    mlsc_lba_t  maxLba;
    logic [27:0] max28;
    mlsc_byte_t rdData;
    logic       rdValid;
    logic       intrq;
    logic       accessAbort;
    logic       nvWrite;
    logic       spinDownReq;
  } mlsc_dev_s;

  mlsc_dev_s state_reg;
  mlsc_dev_s state_next;
  mlsc_lba_t reqLba;
  logic      reqNv;
  logic      abortSetMax;
  logic      srstWrite;

  // ************************************************************
  // task-file read mux
  // ************************************************************
  function automatic mlsc_byte_t readTf(input mlsc_dev_s s, input logic ctl,
                                        input logic [2:0] addr);
    mlsc_byte_t v;
    v = 8'h00;
    if (ctl)
    begin
      v = s.status;
    end
    else
    begin
      unique case (addr)
        `MLSC_TF_FEATURE: v = s.error;
        `MLSC_TF_SECCNT:  v = s.hob ? s.scPrev : s.scCur;
        `MLSC_TF_SECNUM:  v = s.hob ? s.lbaPrev[7:0]   : s.lbaCur[7:0];
        `MLSC_TF_CYLLO:   v = s.hob ? s.lbaPrev[15:8]  : s.lbaCur[15:8];
        `MLSC_TF_CYLHI:   v = s.hob ? s.lbaPrev[23:16] : s.lbaCur[23:16];
        `MLSC_TF_DEVHEAD: v = s.devHead;
        `MLSC_TF_COMMAND: v = s.status;
        default:          v = 8'h00;
      endcase
    end
    return v;
  endfunction

  // ************************************************************
  // next-state logic
  // ************************************************************
  assign reqLba = {state_reg.lbaPrev, state_reg.lbaCur};
  assign reqNv  = state_reg.scCur[`MLSC_SC_NVOPT];
  assign srstWrite = tf.tfWr && tf.tfCtl && (tf.tfAddr == `MLSC_TF_DEVCTL)
                     && tf.tfWrData[`MLSC_DC_SRST];

  always_comb
  begin
    abortSetMax = !SUPPORT_EXT
                  || !state_reg.devHead[`MLSC_DH_LBA]
                  || !state_reg.lastNativeExt
                  || (reqLba > nativeMaxLba)
                  || hpa28Established
                  || protLocked
                  || protFrozen
                  || (reqNv && addrOffsetMode)
                  || (reqNv && state_reg.nvUsed);
  end

  always_comb
  begin
    state_next = state_reg;
    state_next.rdValid     = 1'b0;
    state_next.nvWrite     = 1'b0;
    state_next.spinDownReq = 1'b0;
    state_next.powerUp     = 1'b0;
    state_next.accessAbort = accessReq && (accessLba > state_reg.maxLba);
    if (state_reg.powerUp)
    begin
      // volatile maximum is gone after power-on; a stored one survives
      state_next.maxLba = nvStoredValid ? nvStoredLba : nativeMaxLba;
      state_next.max28  = nvStoredValid ? nvStoredLba[27:0] : nativeMaxLba[27:0];
    end
    if (tf.hardReset || srstWrite)
    begin
      // both resets wake the drive and restore status and error; the task-file bytes are kept
      state_next.st            = MLSC_IDLE;
      state_next.status        = `MLSC_STATUS_RST;
      state_next.error         = `MLSC_ERROR_RST;
      state_next.intrq         = 1'b0;
      state_next.lastNativeExt = 1'b0;
      state_next.hob           = 1'b0;
      if (tf.hardReset)
      begin
        state_next.nvUsed = 1'b0;
      end
    end
    else
    begin
      unique case (state_reg.st)
        MLSC_IDLE:
        begin
          if (tf.tfRd)
          begin
            state_next.rdData  = readTf(state_reg, tf.tfCtl, tf.tfAddr);
            state_next.rdValid = 1'b1;
            if (!tf.tfCtl && tf.tfAddr == `MLSC_TF_COMMAND)
            begin
              state_next.intrq = 1'b0;
            end
          end
          if (tf.tfWr && tf.tfCtl && tf.tfAddr == `MLSC_TF_DEVCTL)
          begin
            state_next.hob = tf.tfWrData[`MLSC_DC_HOB];
          end
          else if (tf.tfWr && !state_reg.status[`MLSC_ST_BSY])
          begin
            state_next.hob = 1'b0;
            unique case (tf.tfAddr)
              `MLSC_TF_FEATURE: state_next.feature = tf.tfWrData;
              `MLSC_TF_SECCNT:
              begin
                state_next.scPrev = state_reg.scCur;
                state_next.scCur  = tf.tfWrData;
              end
              `MLSC_TF_SECNUM:
              begin
                state_next.lbaPrev[7:0] = state_reg.lbaCur[7:0];
                state_next.lbaCur[7:0]  = tf.tfWrData;
              end
              `MLSC_TF_CYLLO:
              begin
                state_next.lbaPrev[15:8] = state_reg.lbaCur[15:8];
                state_next.lbaCur[15:8]  = tf.tfWrData;
              end
              `MLSC_TF_CYLHI:
              begin
                state_next.lbaPrev[23:16] = state_reg.lbaCur[23:16];
                state_next.lbaCur[23:16]  = tf.tfWrData;
              end
              `MLSC_TF_DEVHEAD: state_next.devHead = tf.tfWrData;
              `MLSC_TF_COMMAND:
              begin
                state_next.cmd    = tf.tfWrData;
                state_next.status = 8'h80;
                state_next.intrq  = 1'b0;
                state_next.st     = MLSC_EXEC;
              end
              default: state_next.feature = state_reg.feature;
            endcase
          end
        end
        MLSC_EXEC:
        begin
          state_next.st            = MLSC_IDLE;
          state_next.status        = `MLSC_STATUS_RST;
          state_next.error         = 8'h00;
          state_next.intrq         = 1'b1;
          state_next.lastNativeExt = 1'b0;
          if (state_reg.cmd == `MLSC_OP_SETMAXEXT)
          begin
            if (abortSetMax)
            begin
              state_next.error  = 8'h04;
              state_next.status = 8'h51;
            end
            else
            begin
              state_next.maxLba  = reqLba;
              state_next.nvUsed  = state_reg.nvUsed | reqNv;
              state_next.nvWrite = reqNv;
              if (reqLba <= `MLSC_LBA28_MAX)
              begin
                state_next.max28 = reqLba[27:0];
              end
            end
          end
          else if (state_reg.cmd == `MLSC_OP_RDNATEXT)
          begin
            state_next.lbaCur        = nativeMaxLba[23:0];
            state_next.lbaPrev       = nativeMaxLba[47:24];
            state_next.lastNativeExt = 1'b1;
          end
          else if (state_reg.cmd == `MLSC_OP_SLEEP_A ||
                   state_reg.cmd == `MLSC_OP_SLEEP_B)
          begin
            state_next.spinDownReq = mediaSpinning;
            state_next.st = mediaSpinning ? MLSC_SPIN : MLSC_SLEEP;
            state_next.status[`MLSC_ST_RDY] = 1'b0;
            state_next.status[`MLSC_ST_BSY] = mediaSpinning;
            state_next.intrq = !mediaSpinning;
          end
          else
          begin
            state_next.error  = 8'h04;
            state_next.status = 8'h51;
          end
        end
        MLSC_SPIN:
        begin
          if (!mediaSpinning)
          begin
            state_next.st     = MLSC_SLEEP;
            state_next.status = 8'h10;
            state_next.intrq  = 1'b1;
          end
        end
        MLSC_SLEEP:
        begin
          state_next.st = MLSC_SLEEP; // register activity ignored
        end
        default:
        begin
          state_next.st = MLSC_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= '{st: MLSC_IDLE, status: `MLSC_STATUS_RST, error: `MLSC_ERROR_RST,
                     powerUp: 1'b1, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tf.tfRdData      = state_reg.rdData;
  assign tf.tfRdValid     = state_reg.rdValid;
  assign tf.intrq         = state_reg.intrq;
  assign accessAbort      = state_reg.accessAbort;
  assign maxLba           = state_reg.maxLba;
  assign idWords103to100  = {16'h0000, state_reg.maxLba};
  assign idWords61to60    = {4'h0, state_reg.max28};
  assign nvWrite          = state_reg.nvWrite;
  assign spinDownReq      = state_reg.spinDownReq;
  assign asleep           = (state_reg.st == MLSC_SLEEP);
endmodule // mlsc_device
`default_nettype wire

// ### rtl/mlsc_host.sv
// host end: apb-driven task-file access controller
`timescale 1ns/1ps
`default_nettype none
`include "mlsc_consts.svh"
module mlsc_host (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  mlsc_tf_if.host          tf,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  import mlsc_pkg::*;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       ctl;
    logic [2:0] addr;
    mlsc_byte_t data;
    logic       busy;
    mlsc_byte_t result;
    logic       hardReset;
  } mlsc_host_s;

  mlsc_host_s state_reg;
  mlsc_host_s state_next;
  logic       apbWrite;
  logic       accHit;

  // ************************************************************
  // apb decode and task-file sequencing
  // ************************************************************
  assign apbWrite = psel && penable && pwrite;
  assign accHit   = apbWrite && (paddr == `MLSC_APB_ACCESS);
  assign pready   = 1'b1;

  always_comb
  begin
    state_next    = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;
    pslverr       = 1'b0;
    prdata        = 32'h0000_0000;
    if (state_reg.wr)
    begin
      state_next.busy = 1'b0;
    end
    if (state_reg.busy && tf.tfRdValid)
    begin
      state_next.result = tf.tfRdData;
      state_next.busy   = 1'b0;
    end
    if (state_reg.hardReset)
    begin
      // a read sent to a sleeping drive is never answered; the wake frees the port
      state_next.busy = 1'b0;
    end
    if (psel && penable)
    begin
      unique case (paddr)
        `MLSC_APB_ACCESS:
        begin
          // writes go to the current byte; the drive shifts the old one
          pslverr = state_reg.busy || !pwrite;
          if (accHit && !state_reg.busy)
          begin
            state_next.rd   = pwdata[`MLSC_ACC_READ];
            state_next.wr   = !pwdata[`MLSC_ACC_READ];
            state_next.ctl  = pwdata[`MLSC_ACC_CTL];
            state_next.addr = pwdata[10:8];
            state_next.data = pwdata[7:0];
            state_next.busy = 1'b1;
          end
        end
        `MLSC_APB_RESULT:
        begin
          pslverr = pwrite;
          prdata  = {22'h00_0000, tf.intrq, state_reg.busy, state_reg.result};
        end
        `MLSC_APB_CTRL:
        begin
          if (pwrite)
          begin
            state_next.hardReset = pwdata[0]; // one wake path out of sleep; a soft reset is the other
          end
          prdata = {31'h0000_0000, state_reg.hardReset};
        end
        default:
        begin
          pslverr = 1'b1;
        end
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign tf.tfWr      = state_reg.wr;
  assign tf.tfRd      = state_reg.rd;
  assign tf.tfCtl     = state_reg.ctl;
  assign tf.tfAddr    = state_reg.addr;
  assign tf.tfWrData  = state_reg.data;
  assign tf.hardReset = state_reg.hardReset;
endmodule // mlsc_host
`default_nettype wire

// ### testbench/mlsc_chk_sva.sv
// checker for the task-file link between the host and drive ends
`timescale 1ns/1ps
`default_nettype none
module mlsc_chk (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       tfWr,
  input wire logic       tfRd,
  input wire logic       tfCtl,
  input wire logic [2:0] tfAddr,
  input wire logic [7:0] tfWrData,
  input wire logic       hardReset,
  input wire logic [7:0] tfRdData,
  input wire logic       tfRdValid,
  input wire logic       intrq
);
  logic slpPend;
  logic slpSeen;
  logic cmdWr;
  logic stRd;
  logic ctlWr;
  logic isSlp;
  assign cmdWr = tfWr && !tfCtl && tfAddr == 3'h7;
  assign stRd  = tfRd && !tfCtl && tfAddr == 3'h7;
  assign ctlWr = tfWr && tfCtl;
  assign isSlp = tfWrData == 8'he6 || tfWrData == 8'h99;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************
  // sleep tracking
  // ****************
  // asleep once a sleep command has completed; left only by either reset
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slpPend <= 1'b0;
      slpSeen <= 1'b0;
    end
    else if (hardReset || (ctlWr && tfWrData[2]))
    begin
      slpPend <= 1'b0;
      slpSeen <= 1'b0;
    end
    else
    begin
      if (cmdWr && isSlp && !slpSeen)
        slpPend <= 1'b1;
      if (slpPend && $rose(intrq))
        slpSeen <= 1'b1;
    end
  end
  // ****************
  // assertions
  // ****************
  cmd_done_a: assert property (cmdWr && !isSlp && !slpSeen && !hardReset |-> ##2 intrq)
    else $error("command not completed two cycles after its write");
  rd_ans_a: assert property (tfRd && !slpSeen && !hardReset |=> tfRdValid)
    else $error("read not answered while awake");
  rd_mute_a: assert property (tfRd && slpSeen |=> !tfRdValid [*2])
    else $error("read answered while asleep");
  rd_cause_a: assert property (tfRdValid |-> $past(tfRd))
    else $error("read data without a read strobe");
  irq_clear_a: assert property (stRd && !slpSeen |=> !intrq)
    else $error("status read did not clear the interrupt");
  irq_hold_a: assert property (intrq && !stRd && !cmdWr && !ctlWr && !hardReset |=> intrq)
    else $error("interrupt dropped without a cause");
  data_hold_a: assert property (!tfRdValid && !$past(hardReset) && !$past(ctlWr)
    |-> $stable(tfRdData))
    else $error("read data changed without a new read");
  strobe_one_a: assert property (tfWr || tfRd |=> !tfWr && !tfRd)
    else $error("strobe longer than one cycle");
  strobe_excl_a: assert property (!(tfWr && tfRd))
    else $error("read and write strobes together");
  cover property (tfRdValid && tfRdData == 8'h51);
  cover property ($rose(slpSeen));
  cover property (stRd ##1 tfRdValid && tfRdData == 8'h50);
endmodule // mlsc_chk
`default_nettype wire

// ### testbench/test_max_lba_limit_and_sleep_cmd.sv
// self-checking bench for the max-limit and sleep command ends
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin nFail++; \
  $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module test_max_lba_limit_and_sleep_cmd;
  import mlsc_pkg::*;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rnd, r;
  mlsc_lba_t   nativeMax, accLba, maxLba, curMax, v;
  logic [63:0] idHi;
  logic [31:0] idLo;
  logic        hpa, locked, frozen, offMode, spinning, accReq, accAbort;
  logic        nvWrite, spinReq, asleep, e;
  logic [7:0]  expQ[$];
  logic [7:0]  eRd;
  mlsc_lba_t   nvLba = 48'h0000_0000_0000;
  logic        nvValid = 1'b0;
  int          nFail, compares, nvCount, spinCount, i;
  mlsc_tf_if   tf ();
  mlsc_device mlsc_device_inst (.clk(clk), .sys_rst(sys_rst), .tf(tf.device),
    .nativeMaxLba(nativeMax), .nvStoredLba(nvLba), .nvStoredValid(nvValid),
    .hpa28Established(hpa), .protLocked(locked), .protFrozen(frozen),
    .addrOffsetMode(offMode), .mediaSpinning(spinning), .accessLba(accLba),
    .accessReq(accReq), .accessAbort(accAbort), .maxLba(maxLba), .idWords103to100(idHi),
    .idWords61to60(idLo), .nvWrite(nvWrite), .spinDownReq(spinReq), .asleep(asleep));
  mlsc_host mlsc_host_inst (.clk(clk), .sys_rst(sys_rst), .tf(tf.host), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));
  mlsc_chk mlsc_chk_inst (.clk(clk), .sys_rst(sys_rst), .tfWr(tf.tfWr), .tfRd(tf.tfRd),
    .tfCtl(tf.tfCtl), .tfAddr(tf.tfAddr), .tfWrData(tf.tfWrData), .hardReset(tf.hardReset),
    .tfRdData(tf.tfRdData), .tfRdValid(tf.tfRdValid), .intrq(tf.intrq));
  // ****************
  // tasks
  // ****************
  function automatic logic [31:0] nxt(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic conclude();
    $display("compares %0d mismatches %0d", compares, nFail);
    if (nFail == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic er);
    int k;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    q = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k == 20)
    begin
      nFail++;
      conclude();
    end
    @(posedge clk);
  endtask
  // poll the host until its task-file access has finished
  task automatic idle();
    logic [31:0] q;
    logic er;
    int k;
    for (k = 0; k < 40; k++)
    begin
      apb(1'b0, 12'h004, 32'h0000_0000, q, er);
      if (q[8] === 1'b0)
        break;
    end
    if (k == 40)
    begin
      nFail++;
      conclude();
    end
  endtask
  task automatic acc(input logic rd, input logic c, input logic [2:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic er;
    apb(1'b1, 12'h000, {19'h0_0000, rd, c, a, d}, q, er);
    idle();
  endtask
  task automatic tfw(input logic [2:0] a, input logic [7:0] d);
    acc(1'b0, 1'b0, a, d);
  endtask
  task automatic tfr(input logic [2:0] a, input logic [7:0] x);
    expQ.push_back(x);
    acc(1'b1, 1'b0, a, 8'h00);
  endtask
  // pre: 0 no native read, 1 native read, 2 native read then another command
  task automatic sm(input mlsc_lba_t m, input logic b, input logic [1:0] pre,
                    input logic [7:0] dh, input logic ok);
    int k;
    tfw(3'h6, 8'h40);
    if (pre != 2'd0)
    begin
      tfw(3'h7, 8'h27);
      tfr(3'h7, 8'h50);
    end
    if (pre == 2'd2)
    begin
      tfw(3'h7, 8'h00);
      tfr(3'h7, 8'h51);
    end
    for (k = 0; k < 6; k++)
      tfw(3'(3 + k % 3), m[8 * ((k % 3) + 3 * (k < 3)) +: 8]);
    tfw(3'h2, {7'h00, b});
    tfw(3'h6, dh);
    tfw(3'h7, 8'h37);
    tfr(3'h7, ok ? 8'h50 : 8'h51);
    tfr(3'h1, ok ? 8'h00 : 8'h04);
    if (ok)
      curMax = m;
    `CHK(maxLba, curMax)
  endtask
  // ****************
  // clock, monitor and sequence
  // ****************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (nvWrite === 1'b1)
    begin
      nvCount++;
      // persistent store keeps the accepted maximum across power-on
      nvLba   <= maxLba;
      nvValid <= 1'b1;
    end
    if (spinReq === 1'b1)
      spinCount++;
    if (tf.tfRdValid === 1'b1)
    begin
      eRd = expQ.size() > 0 ? expQ.pop_front() : ~tf.tfRdData;
      `CHK(tf.tfRdData, eRd)
    end
  end
  initial
  begin
    {sys_rst, psel, penable, pwrite, paddr, pwdata} = {4'h8, 12'h000, 32'h0000_0000};
    {hpa, locked, frozen, offMode, spinning, accReq} = 6'h00;
    rnd = 32'h72d1_8d39;
    nativeMax = {16'h0001, rnd};
    accLba = 48'h0000_0000_0000;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    curMax = nativeMax;
    `CHK(maxLba, curMax)
    apb(1'b1, 12'h0fc, 32'h0000_0000, r, e);
    `CHK(e, 1'b1)
    sm(curMax, 1'b0, 2'd0, 8'h40, 1'b0);
    sm(curMax, 1'b0, 2'd2, 8'h40, 1'b0);
    sm(curMax, 1'b0, 2'd1, 8'h00, 1'b0);
    sm(nativeMax + 48'h0000_0000_0001, 1'b0, 2'd1, 8'h40, 1'b0);
    for (i = 0; i < 3; i++)
    begin
      {hpa, locked, frozen} <= 3'(1 << i);
      sm(nativeMax, 1'b0, 2'd1, 8'h40, 1'b0);
    end
    {hpa, locked, frozen, offMode} <= 4'h1;
    sm(nativeMax, 1'b1, 2'd1, 8'h40, 1'b0);
    offMode <= 1'b0;
    v = 48'h0000_0FFF_FFFF;
    sm(v, 1'b1, 2'd1, 8'h40, 1'b1);
    `CHK(nvCount, 1)
    `CHK(idLo, {4'h0, v[27:0]})
    rnd = nxt(rnd);
    v = {20'h0_0001, rnd[27:0]};
    sm(v, 1'b0, 2'd1, 8'h40, 1'b1);
    `CHK(nvCount, 1)
    `CHK(idLo, 32'h0FFF_FFFF)
    `CHK(idHi, {16'h0000, v})
    acc(1'b0, 1'b1, 3'h6, 8'h80);
    for (i = 0; i < 6; i++)
    begin
      if (i == 3)
        acc(1'b0, 1'b1, 3'h6, 8'h00);
      tfr(3'(3 + i % 3), v[8 * ((i % 3) + 3 * (i < 3)) +: 8]);
    end
    sm(v - 48'h0000_0000_0001, 1'b1, 2'd1, 8'h40, 1'b0);
    for (i = 0; i < 2; i++)
    begin
      accLba <= curMax + 48'(i);
      accReq <= 1'b1;
      repeat (2) @(posedge clk);
      `CHK(accAbort, 1'(i))
    end
    accReq <= 1'b0;
    tfw(3'h7, 8'he6);
    `CHK(asleep, 1'b1)
    `CHK(spinCount, 0)
    acc(1'b0, 1'b1, 3'h6, 8'h04);
    acc(1'b0, 1'b1, 3'h6, 8'h00);
    `CHK(asleep, 1'b0)
    tfr(3'h7, 8'h50);
    spinning <= 1'b1;
    tfw(3'h7, 8'h99);
    `CHK(spinCount, 1)
    spinning <= 1'b0;
    for (i = 0; i < 20 && asleep !== 1'b1; i++)
      @(posedge clk);
    if (i == 20)
    begin
      nFail++;
      conclude();
    end
    apb(1'b1, 12'h000, 32'h0000_1700, r, e);
    repeat (8) @(posedge clk);
    apb(1'b0, 12'h004, 32'h0000_0000, r, e);
    `CHK(r[8], 1'b1)
    apb(1'b1, 12'h008, 32'h0000_0001, r, e);
    apb(1'b1, 12'h008, 32'h0000_0000, r, e);
    `CHK(asleep, 1'b0)
    tfr(3'h7, 8'h50);
    sm(v, 1'b1, 2'd1, 8'h40, 1'b1);
    `CHK(nvCount, 2)
    sm(nativeMax, 1'b0, 2'd1, 8'h40, 1'b1);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK(maxLba, v)
    `CHK(expQ.size(), 0)
    conclude();
  end
endmodule // test_max_lba_limit_and_sleep_cmd
`default_nettype wire
